// File: iqm_chain.sv
// fine mixer, iq correction, offsets and coarse mixer with an axi4-lite register file
`timescale 1ns/100ps
`default_nettype none
module iqm_chain #(
  parameter int DAC_RATE_MHZ = 500
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              in_valid,
  input  wire iqm_pkg::iqm_pair_s in_pair,
  input  wire logic              phase_strobe_pin,
  output logic                   out_valid,
  output iqm_pkg::iqm_pair_s     out_pair,
  output logic                   sleep_a,
  output logic                   sleep_b,
  output logic [3:0]             fs_a_coarse,
  output logic [7:0]             fs_a_fine,
  output logic [3:0]             fs_b_coarse,
  output logic [7:0]             fs_b_fine,
  output logic                   rate_fault
);
  import iqm_pkg::*;

  // clamp a wide signed value to the 16-bit sample range
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767)
      return 16'sh7FFF;
    else if (v < -40'sd32768)
      return 16'sh8000;
    else
      return v[15:0];
  endfunction

  // negate without wrapping the most negative code
  function automatic logic signed [15:0] neg16(input logic signed [15:0] v);
    return (v == 16'sh8000) ? 16'sh7FFF : -v;
  endfunction

  logic [31:0]        tuning;
  logic [15:0]        phase_ofs;
  logic [7:0]         cfg;
  logic [10:0]        gain_i;
  logic [10:0]        gain_q;
  logic [9:0]         trim;
  logic [12:0]        ofs_i;
  logic [12:0]        ofs_q;
  logic [11:0]        fs_a;
  logic [11:0]        fs_b;
  logic [1:0]         ctrl;
  logic               aw_got;
  logic               w_got;
  logic [5:0]         wr_idx;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               wr_go;
  logic               strobe_s1;
  logic               strobe_s2;
  logic               strobe_d;
  logic               strobe_rise;
  logic [31:0]        acc;
  logic               half_tog;
  logic               osc_en;
  logic [31:0]        phase_now;
  logic signed [23:0] rot_x;
  logic signed [23:0] rot_y;
  logic               v1;
  logic               v2;
  iqm_pair_s          fm;
  iqm_pair_s          qc;
  logic [1:0]         cm_idx;
  logic [1:0]         interp;
  logic [3:0]         coarse_sequence_select;

  assign interp  = cfg[CFG_INTERP_LSB +: 2];
  assign coarse_sequence_select = cfg[3:0];
  // x4 runs the oscillator and correction at the full rate; flag a rate beyond their limit
  assign rate_fault = (interp == INTERP_X4) &&
                      (DAC_RATE_MHZ > NCO_MAX_MHZ || DAC_RATE_MHZ > QMC_MAX_MHZ);

  // bus handshake: address and data taken in either order, answer after both
  assign awready = !aw_got && !bvalid;
  assign wready  = !w_got && !bvalid;
  assign arready = !rvalid;
  assign wr_go   = aw_got && w_got && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wr_idx  <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        wr_idx <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        w_got   <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= ((wr_idx >= IDX_TUNE0 && wr_idx <= IDX_PHOFS1) ||
                   (wr_idx >= IDX_CFG && wr_idx <= IDX_CTRL)) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register file; a byte register takes lane 0, wider fields lanes 0 and 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tuning    <= '0;
      phase_ofs <= '0;
      cfg       <= RST_CFG;
      gain_i    <= RST_GAIN;
      gain_q    <= RST_GAIN;
      trim      <= '0;
      ofs_i     <= '0;
      ofs_q     <= '0;
      fs_a      <= RST_FS;
      fs_b      <= RST_FS;
      ctrl      <= '0;
    end else if (wr_go) begin
      if (wr_strb[0]) begin
        case (wr_idx)
          IDX_TUNE0:  tuning[7:0]     <= wr_data[7:0];
          IDX_TUNE1:  tuning[15:8]    <= wr_data[7:0];
          IDX_TUNE2:  tuning[23:16]   <= wr_data[7:0];
          IDX_TUNE3:  tuning[31:24]   <= wr_data[7:0];
          IDX_PHOFS0: phase_ofs[7:0]  <= wr_data[7:0];
          IDX_PHOFS1: phase_ofs[15:8] <= wr_data[7:0];
          IDX_CFG:    cfg             <= wr_data[7:0];
          IDX_GAIN_I: gain_i[7:0]     <= wr_data[7:0];
          IDX_GAIN_Q: gain_q[7:0]     <= wr_data[7:0];
          IDX_TRIM:   trim[7:0]       <= wr_data[7:0];
          IDX_OFS_I:  ofs_i[7:0]      <= wr_data[7:0];
          IDX_OFS_Q:  ofs_q[7:0]      <= wr_data[7:0];
          IDX_FS_A:   fs_a[7:0]       <= wr_data[7:0];
          IDX_FS_B:   fs_b[7:0]       <= wr_data[7:0];
          IDX_CTRL:   ctrl            <= wr_data[1:0];
          default: ;
        endcase
      end
      if (wr_strb[1]) begin
        case (wr_idx)
          IDX_GAIN_I: gain_i[10:8] <= wr_data[10:8];
          IDX_GAIN_Q: gain_q[10:8] <= wr_data[10:8];
          IDX_TRIM:   trim[9:8]    <= wr_data[9:8];
          IDX_OFS_I:  ofs_i[12:8]  <= wr_data[12:8];
          IDX_OFS_Q:  ofs_q[12:8]  <= wr_data[12:8];
          IDX_FS_A:   fs_a[11:8]   <= wr_data[11:8];
          IDX_FS_B:   fs_b[11:8]   <= wr_data[11:8];
          default: ;
        endcase
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      case (araddr[7:2])
        IDX_TUNE0:  rdata <= {24'h000000, tuning[7:0]};
        IDX_TUNE1:  rdata <= {24'h000000, tuning[15:8]};
        IDX_TUNE2:  rdata <= {24'h000000, tuning[23:16]};
        IDX_TUNE3:  rdata <= {24'h000000, tuning[31:24]};
        IDX_PHOFS0: rdata <= {24'h000000, phase_ofs[7:0]};
        IDX_PHOFS1: rdata <= {24'h000000, phase_ofs[15:8]};
        IDX_CFG:    rdata <= {24'h000000, cfg};
        IDX_GAIN_I: rdata <= {21'h0, gain_i};
        IDX_GAIN_Q: rdata <= {21'h0, gain_q};
        IDX_TRIM:   rdata <= {22'h0, trim};
        IDX_OFS_I:  rdata <= {19'h0, ofs_i};
        IDX_OFS_Q:  rdata <= {19'h0, ofs_q};
        IDX_FS_A:   rdata <= {20'h00000, fs_a};
        IDX_FS_B:   rdata <= {20'h00000, fs_b};
        IDX_CTRL:   rdata <= {30'h0, ctrl};
        IDX_STAT:   rdata <= {15'h0, rate_fault, acc[31:16]};
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // strobe pin through two flops, then a rising edge detector on the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_d  <= 1'b0;
    end else begin
      strobe_s1 <= phase_strobe_pin;
      strobe_s2 <= strobe_s1;
      strobe_d  <= strobe_s2;
    end
  end
  assign strobe_rise = strobe_s2 && !strobe_d;

  // oscillator tick: every sample in x4, every second sample otherwise
  assign osc_en = in_valid && (interp == INTERP_X4 || half_tog);

  // phase accumulator wraps modulo 2^32; the strobe restarts it and the divider
  always_ff @(posedge aclk) begin
    if (!aresetn || strobe_rise) begin
      acc      <= '0;
      half_tog <= 1'b0;
    end else begin
      if (in_valid)
        half_tog <= !half_tog;
      if (osc_en)
        acc <= acc + tuning;
    end
  end

  // offset word sits at the top 16 bits, so it equals 2 pi times offset over 2^16
  assign phase_now = acc + {phase_ofs, 16'h0000};

  // rotator: quadrant fold, then shift-add steps turning (I,Q) counter-clockwise
  always_comb begin
    logic signed [23:0] x;
    logic signed [23:0] y;
    logic signed [23:0] t;
    logic [31:0]        z;
    x = {{4{in_pair.a[15]}}, in_pair.a, 4'h0};  // four guard bits keep shift truncation off the lsb
    y = {{4{in_pair.b[15]}}, in_pair.b, 4'h0};
    t = '0;
    z = phase_now;
    if (z[31] ^ z[30]) begin
      x = -x;
      y = -y;
      z = z + 32'h80000000;
    end
    for (int i = 0; i < CORDIC_N; i++) begin
      t = x;
      if (!z[31]) begin
        x = x - (y >>> i);
        y = y + (t >>> i);
        z = z - ATAN[i];
      end else begin
        x = x + (y >>> i);
        y = y - (t >>> i);
        z = z + ATAN[i];
      end
    end
    rot_x = x;
    rot_y = y;
  end

  // fine mixer output: undo rotator gain, scale by 2^(boost-1), round and clamp
  always_ff @(posedge aclk) begin
    logic signed [39:0] px;
    logic signed [39:0] py;
    logic signed [39:0] rnd;
    px  = 40'(rot_x * $signed({1'b0, CORDIC_INV_GAIN}));
    py  = 40'(rot_y * $signed({1'b0, CORDIC_INV_GAIN}));
    rnd = cfg[CFG_GAIN_BIT] ? 40'sh0000080000 : 40'sh0000100000;
    if (!aresetn) begin
      v1 <= 1'b0;
      fm <= '0;
    end else begin
      v1 <= in_valid;
      if (in_valid) begin
        fm.a <= sat16((px + rnd) >>> (cfg[CFG_GAIN_BIT] ? 20 : 21));
        fm.b <= sat16((py + rnd) >>> (cfg[CFG_GAIN_BIT] ? 20 : 21));
      end
    end
  end

  // correction stage: gains in 1/1024 steps, trim leaks I into Q, then offsets
  always_ff @(posedge aclk) begin
    logic signed [39:0] ci;
    logic signed [39:0] cq;
    ci = 40'(sat16((40'(fm.a * $signed({1'b0, gain_i})) + 40'sd512) >>> 10));
    cq = 40'(sat16((40'(fm.b * $signed({1'b0, gain_q})) + 40'(fm.a * $signed(trim)) + 40'sd512) >>> 10));
    if (!aresetn) begin
      v2 <= 1'b0;
      qc <= '0;
    end else begin
      v2 <= v1;
      if (v1) begin
        qc.a <= sat16(ci + 40'($signed(ofs_i)));
        qc.b <= sat16(cq + 40'($signed(ofs_q)));
      end
    end
  end

  // coarse mixer sequence position, restarted by the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn || strobe_rise)
      cm_idx <= '0;
    else if (v2)
      cm_idx <= cm_idx + 2'd1;
  end

  // coarse mixer sign patterns, then sleep forces a channel to mid-scale
  always_ff @(posedge aclk) begin
    logic signed [15:0] ma;
    logic signed [15:0] mb;
    ma = qc.a;
    mb = qc.b;
    case (coarse_sequence_select[3:2])
      2'b01: begin
        ma = (!coarse_sequence_select[1] ^ cm_idx[0]) ? neg16(qc.a) : qc.a;
        mb = (!coarse_sequence_select[0] ^ cm_idx[0]) ? neg16(qc.b) : qc.b;
      end
      2'b10: begin
        case (cm_idx)
          2'd0: begin ma = qc.a;        mb = qc.b;        end
          2'd1: begin ma = neg16(qc.b); mb = qc.a;        end
          2'd2: begin ma = neg16(qc.a); mb = neg16(qc.b); end
          default: begin ma = qc.b;     mb = neg16(qc.a); end
        endcase
      end
      2'b11: begin
        case (cm_idx)
          2'd0: begin ma = qc.a;        mb = qc.b;        end
          2'd1: begin ma = qc.b;        mb = neg16(qc.a); end
          2'd2: begin ma = neg16(qc.a); mb = neg16(qc.b); end
          default: begin ma = neg16(qc.b); mb = qc.a;     end
        endcase
      end
      default: ;
    endcase
    if (coarse_sequence_select[3]) begin
      ma = coarse_sequence_select[1] ? neg16(ma) : ma;
      mb = coarse_sequence_select[0] ? neg16(mb) : mb;
    end
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_pair  <= '0;
    end else begin
      out_valid <= v2;
      if (v2) begin
        out_pair.a <= ctrl[0] ? 16'sh0000 : ma;
        out_pair.b <= ctrl[1] ? 16'sh0000 : mb;
      end
    end
  end

  assign sleep_a     = ctrl[0];
  assign sleep_b     = ctrl[1];
  // full-scale codes pass straight to the converter cores
  assign fs_a_coarse = fs_a[11:FS_COARSE_LSB];
  assign fs_a_fine   = fs_a[7:0];
  assign fs_b_coarse = fs_b[11:FS_COARSE_LSB];
  assign fs_b_fine   = fs_b[7:0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  acc_clear_a: assert property (strobe_rise |=> acc == 32'h0) else $error("strobe did not clear accumulator");
  acc_step_a: assert property (osc_en && !strobe_rise |=> acc == $past(acc) + $past(tuning))
    else $error("accumulator step wrong");
  half_rate_a: assert property (interp != INTERP_X4 && in_valid && !half_tog && !strobe_rise
    |=> acc == $past(acc)) else $error("oscillator ticked on a skipped sample");
  latency_a: assert property (in_valid |-> ##3 out_valid) else $error("samples not aligned");
  pass_mode_a: assert property (v2 && coarse_sequence_select[3:2] == 2'b00 && ctrl == 2'b00 |=> out_pair == $past(qc))
    else $error("no-mix mode altered data");
  quarter_a: assert property (v2 && coarse_sequence_select == 4'h8 && cm_idx == 2'd1 && ctrl == 2'b00
    |=> out_pair.b == $past(qc.a)) else $error("quarter rate sequence wrong");
  sleep_zero_a: assert property (out_valid && sleep_a |-> out_pair.a == 16'sh0000)
    else $error("slept channel moving");
  fs_code_a: assert property (wr_go && wr_idx == IDX_FS_A && wr_strb == 4'hF
    |=> fs_a_coarse == $past(wr_data[11:8])) else $error("coarse code not applied");
  write_ans_a: assert property (wr_go |=> bvalid) else $error("write not answered");
endmodule
`default_nettype wire

// File: iqm_pkg.sv
// constants and carrier types for the iq mixer and correction chain
`default_nettype none
package iqm_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TUNE0  = 6'h09;
  localparam logic [5:0] IDX_TUNE1  = 6'h0A;
  localparam logic [5:0] IDX_TUNE2  = 6'h0B;
  localparam logic [5:0] IDX_TUNE3  = 6'h0C;
  localparam logic [5:0] IDX_PHOFS0 = 6'h0D;
  localparam logic [5:0] IDX_PHOFS1 = 6'h0E;
  localparam logic [5:0] IDX_CFG    = 6'h10;
  localparam logic [5:0] IDX_GAIN_I = 6'h11;
  localparam logic [5:0] IDX_GAIN_Q = 6'h12;
  localparam logic [5:0] IDX_TRIM   = 6'h13;
  localparam logic [5:0] IDX_OFS_I  = 6'h14;
  localparam logic [5:0] IDX_OFS_Q  = 6'h15;
  localparam logic [5:0] IDX_FS_A   = 6'h16;
  localparam logic [5:0] IDX_FS_B   = 6'h17;
  localparam logic [5:0] IDX_CTRL   = 6'h18;
  localparam logic [5:0] IDX_STAT   = 6'h19;
  // mixer configuration fields
  localparam int CFG_GAIN_BIT = 6;
  localparam int CFG_INTERP_LSB = 4;
  localparam logic [1:0] INTERP_X2  = 2'h0;
  localparam logic [1:0] INTERP_X4  = 2'h1;
  localparam logic [1:0] INTERP_X4L = 2'h2;
  localparam logic [1:0] INTERP_X8  = 2'h3;
  // full-scale word fields
  localparam int FS_COARSE_LSB = 8;
  // reset values
  localparam logic [7:0]  RST_CFG  = 8'h00;
  localparam logic [10:0] RST_GAIN = 11'h400;
  localparam logic [11:0] RST_FS   = 12'hF00;
  // rate limits of the oscillator and the correction stage
  localparam int NCO_MAX_MHZ = 320;
  localparam int QMC_MAX_MHZ = 320;
  // rotator constants: iterations, inverse gain in q16, atan table in turns of 2^32
  localparam int CORDIC_N = 16;
  localparam logic [15:0] CORDIC_INV_GAIN = 16'h9B75;
  localparam logic [31:0] ATAN [CORDIC_N] = '{
    32'h20000000, 32'h12E4051E, 32'h09FB385B, 32'h051111D4, 32'h028B0D43, 32'h0145D7E1, 32'h00A2F61E,
    32'h00517C55, 32'h0028BE53, 32'h00145F2F, 32'h000A2F98, 32'h000517CC, 32'h00028BE6, 32'h000145F3,
    32'h0000A2FA, 32'h0000517D};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } iqm_pair_s;
endpackage
`default_nettype wire

// File: iqm_source.sv
// sample source model that feeds i/q pairs and the phase strobe pin
`timescale 1ns/100ps
`default_nettype none
module iqm_source (
  input  wire logic          aclk,
  output logic               in_valid,
  output iqm_pkg::iqm_pair_s in_pair,
  output logic               phase_strobe_pin
);
  import iqm_pkg::*;
  // idle outputs at time zero
  initial begin
    in_valid = 1'b0;
    in_pair = '0;
    phase_strobe_pin = 1'b0;
  end
  // one sample per call; gap 0 keeps valid up for a back-to-back sample
  task automatic send(input logic [15:0] a, input logic [15:0] b, input int gap);
    @(posedge aclk);
    in_valid <= 1'b1;
    in_pair <= {a, b};
    if (gap > 0) begin
      @(posedge aclk);
      in_valid <= 1'b0;
      in_pair <= ~{a, b};  // stale data is not left on the bus
      repeat (gap - 1) @(posedge aclk);
    end
  endtask
  // strobe pin pulse, then time for the synchroniser
  task automatic strobe();
    @(posedge aclk);
    phase_strobe_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    phase_strobe_pin <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the iq mixer and correction chain
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, t) begin n_compared++; if (^(g) === 1'bx || ((g) !== (e) && \
  ((((g) > (e)) ? (g) - (e) : (e) - (g)) > (t)))) begin num_errors++; \
  $display("CHECK FAILED %0t: got %0d exp %0d", $time, (g), (e)); end end
module tb_top;
  import iqm_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, in_valid, strb, out_valid, sleep_a, sleep_b, rate_fault;
  logic [7:0]  awaddr, araddr, fs_a_fine, fs_b_fine;
  logic [31:0] wdata, rdata, rd, seed, tw, v;
  logic [3:0]  wstrb, fs_a_coarse, fs_b_coarse, mode;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  vh;
  logic [11:0] fsa, fsb;
  iqm_pair_s   in_pair, out_pair;
  int          num_errors, n_compared, boost, gi, gq, tr, oi, oq, ph, sla, slb, cidx, ea, eb, i, j;
  int          qa[$], qb[$];
  localparam logic [5:0] RIDX [15] = '{IDX_TUNE0, IDX_TUNE1, IDX_TUNE2, IDX_TUNE3, IDX_PHOFS0, IDX_PHOFS1,
    IDX_CFG, IDX_GAIN_I, IDX_GAIN_Q, IDX_TRIM, IDX_OFS_I, IDX_OFS_Q, IDX_FS_A, IDX_FS_B, IDX_CTRL};
  localparam logic [12:0] RMSK [15] = '{13'h0FF, 13'h0FF, 13'h0FF, 13'h0FF, 13'h0FF, 13'h0FF, 13'h0FF,
    13'h7FF, 13'h7FF, 13'h3FF, 13'h1FFF, 13'h1FFF, 13'hFFF, 13'hFFF, 13'h003};

  iqm_chain #(.DAC_RATE_MHZ(500)) u_iqm_chain (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_valid(in_valid), .in_pair(in_pair),
    .phase_strobe_pin(strb), .out_valid(out_valid), .out_pair(out_pair), .sleep_a(sleep_a),
    .sleep_b(sleep_b), .fs_a_coarse(fs_a_coarse), .fs_a_fine(fs_a_fine), .fs_b_coarse(fs_b_coarse),
    .fs_b_fine(fs_b_fine), .rate_fault(rate_fault));
  iqm_source u_iqm_source (.aclk(aclk), .in_valid(in_valid), .in_pair(in_pair), .phase_strobe_pin(strb));

  // 50 mhz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic int sat(input real x);
    int y;
    y = (x < 0.0) ? -$rtoi(0.5 - x) : $rtoi(x + 0.5);
    return (y > 32767) ? 32767 : (y < -32768) ? -32768 : y;
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic fail_wait();
    num_errors++;
    $display("CHECK FAILED %0t: wait timed out", $time);
    complete_run();
  endtask

  // axi4-lite write: address and data offered together, each released when taken
  task automatic axw(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (!ga && awready) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) fail_wait();
    `CHK(r, er, 0)
  endtask

  // axi4-lite read
  task automatic axr(input logic [5:0] idx, input logic [1:0] er);
    int n;
    logic ga;
    ga = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (!ga && arready) begin
        ga = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rd = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) fail_wait();
    `CHK(r, er, 0)
  endtask

  // reference model of one sample through rotation, correction, offset and coarse sequence
  task automatic push(input int a, input int b);
    real th, s;
    int i1, q1, xa, xb, k;
    th = 6.283185307179586 * ph / 65536.0;
    s = boost ? 1.0 : 0.5;
    i1 = sat((a * $cos(th) - b * $sin(th)) * s);
    q1 = sat((a * $sin(th) + b * $cos(th)) * s);
    q1 = sat(sat((q1 * gq + i1 * tr) / 1024.0) + oq);
    i1 = sat(sat(i1 * gi / 1024.0) + oi);
    k = cidx % 4;
    cidx++;
    xa = i1;
    xb = q1;
    if (mode[3:2] == 2'b01) begin
      xa = ((k % 2 == 0) == mode[1]) ? i1 : -i1;
      xb = ((k % 2 == 0) == mode[0]) ? q1 : -q1;
    end else if (mode[3]) begin
      xa = (k == 0) ? i1 : (k == 2) ? -i1 : ((k == 1) ^ mode[2]) ? -q1 : q1;
      xb = (k == 0) ? q1 : (k == 2) ? -q1 : ((k == 3) ^ mode[2]) ? -i1 : i1;
      if (mode[1]) xa = -xa;
      if (mode[0]) xb = -xb;
    end
    qa.push_back(sla ? 0 : sat(xa));
    qb.push_back(slb ? 0 : sat(xb));
  endtask

  // one datapath pass for a coarse mode with random correction settings
  task automatic run_pass(input logic [3:0] m);
    int n;
    v = rnd();
    mode = m;
    boost = (m < 4) ? 0 : v[31];
    gi = (m < 4) ? 1446 : v[10:0];
    gq = (m < 4) ? 1446 : v[26:16];
    tr = $signed(v[21:12]);
    v = rnd();
    oi = $signed(v[12:0]);
    oq = $signed(v[28:16]);
    ph = rnd() & 32'h0000FFFF;
    sla = (m == 13);
    slb = (m == 14);
    axw(IDX_CFG, {24'h0, 1'b0, boost[0], v[1:0], m}, RESP_OKAY);
    axw(IDX_GAIN_I, gi, RESP_OKAY);
    axw(IDX_GAIN_Q, gq, RESP_OKAY);
    axw(IDX_TRIM, tr, RESP_OKAY);
    axw(IDX_OFS_I, oi, RESP_OKAY);
    axw(IDX_OFS_Q, oq, RESP_OKAY);
    axw(IDX_PHOFS0, ph & 255, RESP_OKAY);
    axw(IDX_PHOFS1, ph >> 8, RESP_OKAY);
    axw(IDX_CTRL, {30'h0, slb[0], sla[0]}, RESP_OKAY);
    u_iqm_source.strobe();
    cidx = 0;
    for (n = 0; n < 8; n++) begin
      v = (n == 0) ? 32'h7FFF8000 : rnd();
      push($signed(v[31:16]), $signed(v[15:0]));
      u_iqm_source.send(v[31:16], v[15:0], (n == 7) ? 6 : n % 2);
    end
    for (n = 0; n < 40 && qa.size() > 0; n++) @(posedge aclk);
    if (qa.size() > 0) fail_wait();
  endtask

  // output timing and data against the reference model
  always @(posedge aclk) begin
    if (!aresetn) begin
      vh = 3'b000;
    end else begin
      if (out_valid || vh[2]) `CHK(out_valid, vh[2], 0)
      if (out_valid && qa.size() > 0) begin
        ea = qa.pop_front();
        eb = qb.pop_front();
        `CHK($signed(out_pair.a), ea, 8)
        `CHK($signed(out_pair.b), eb, 8)
      end
      vh = {vh[1:0], in_valid};
    end
  end

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    seed = 32'h9A8B;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(fs_a_coarse, RST_FS[11:8], 0)
    `CHK(rate_fault, 1'b0, 0)
    for (i = 0; i < 15; i++) begin
      axr(RIDX[i], RESP_OKAY);
      v = (RIDX[i] == IDX_GAIN_I || RIDX[i] == IDX_GAIN_Q) ? {21'h0, RST_GAIN} :
          (RIDX[i] == IDX_FS_A || RIDX[i] == IDX_FS_B) ? {20'h0, RST_FS} : 32'h0;
      `CHK(rd, v, 0)
      v = rnd();
      axw(RIDX[i], v, RESP_OKAY);
      axr(RIDX[i], RESP_OKAY);
      `CHK(rd, v & RMSK[i], 0)
      if (RIDX[i] == IDX_FS_A) fsa = v[11:0];
      if (RIDX[i] == IDX_FS_B) fsb = v[11:0];
    end
    `CHK({fs_a_coarse, fs_a_fine, fs_b_coarse, fs_b_fine}, {fsa, fsb}, 0)
    `CHK({sleep_b, sleep_a}, v[1:0], 0)
    axr(6'h0F, RESP_SLVERR);
    `CHK(rd, 32'h0, 0)
    axw(IDX_STAT, 32'hFFFF, RESP_SLVERR);
    axw(6'h3F, 32'h1, RESP_SLVERR);
    for (j = 0; j < 4; j++) axw(RIDX[j], 32'h0, RESP_OKAY);
    for (i = 0; i < 16; i++) run_pass(i[3:0]);
    // accumulator stepping in each interpolation mode
    for (i = 0; i < 4; i++) begin
      tw = rnd();
      tw[31] = i[0];
      for (j = 0; j < 4; j++) axw(RIDX[j], tw >> (8 * j), RESP_OKAY);
      axw(IDX_CFG, {26'h0, i[1:0], 4'h0}, RESP_OKAY);
      u_iqm_source.strobe();
      axr(IDX_STAT, RESP_OKAY);
      `CHK(rd[15:0], 16'h0000, 0)
      for (j = 0; j < 7; j++) u_iqm_source.send(v[31:16], v[15:0], (j == 6) ? 4 : 0);
      axr(IDX_STAT, RESP_OKAY);
      tw = tw * ((i == 1) ? 7 : 3);
      `CHK(rd[15:0], tw[31:16], 0)
      `CHK(rd[16], i == 1, 0)
      `CHK(rate_fault, i == 1, 0)
    end
    complete_run();
  end
endmodule
`default_nettype wire
